//--- verilog/tmr_pkg.sv
// constants for the timer upper-byte, compare, period and irq registers
// assumes a 32-bit avalon-mm slave port with byte addresses
package tmr_pkg;
  localparam int          NCH        = 4;
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 32;
  localparam int          NFLAG      = 6;
  // register indices; byte address is four times the index
  localparam logic [13:0] CTRL_IDX   [NCH] =
    '{14'h00BA, 14'h00C2, 14'h00CA, 14'h2F38};
  localparam logic [13:0] CNT_HI_IDX [NCH] =
    '{14'h00BD, 14'h00C5, 14'h00CD, 14'h2F3B};
  localparam logic [13:0] CMP_LO_IDX [NCH] =
    '{14'h00BE, 14'h00C6, 14'h00CE, 14'h2F3C};
  localparam logic [13:0] CMP_HI_IDX [NCH] =
    '{14'h00BF, 14'h00C7, 14'h00CF, 14'h2F3D};
  localparam logic [13:0] STATUS_IDX = 14'h00D5;
  localparam logic [13:0] IRQ_EN_IDX = 14'h3000;
  localparam logic [13:0] IRQ_CLR_IDX = 14'h3001;
  // reset values
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [7:0]  RST_CMP    = 8'hFF;
  localparam logic [7:0]  RST_PER    = 8'hFF;
  localparam logic [7:0]  RST_DUTY   = 8'h00;
  localparam logic [5:0]  RST_STATUS = 6'h00;
  localparam logic [5:0]  RST_IRQ_EN = 6'h00;
  // control register fields
  localparam int          CTL_START  = 0;
  localparam int          CTL_CLK_LO = 2;
  localparam int          CTL_CAP    = 5;
  localparam int          CTL_PWM    = 6;
  // prescaler terminal counts, divide by 1,4,8,16,64,256,1024,2048
  localparam logic [10:0] DIV_LAST [8] =
    '{11'h000, 11'h003, 11'h007, 11'h00F,
      11'h03F, 11'h0FF, 11'h3FF, 11'h7FF};
endpackage

//--- verilog/tmr_chan.sv
// one 16-bit timer/counter/capture/pwm channel with its prescaler
// assumes capture edge is already synchronised to ref_clk
`timescale 1ns/10ps
module tmr_chan (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // control from the register file
  input  wire logic        restart,
  input  wire logic        run,
  input  wire logic        cap_mode,
  input  wire logic        pwm_en,
  input  wire logic [2:0]  clk_sel,
  input  wire logic [15:0] compare,
  input  wire logic [15:0] period,
  input  wire logic [7:0]  duty_high,
  input  wire logic        cap_edge,
  // state back to the register file
  output logic      [15:0] count,
  output logic      [15:0] captured,
  output logic             event_p,
  output logic             pwm
);
  typedef struct packed {
    logic [10:0] pre;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic        evt;
    logic        pwm;
  } tmr_chan_st_t;

  tmr_chan_st_t s;
  tmr_chan_st_t n;
  logic         tick;

  // prescaler, counter, capture and pwm compare
  always_comb begin
    n     = s;
    n.evt = 1'b0;
    tick  = (s.pre >= tmr_pkg::DIV_LAST[clk_sel]); // R13
    if (restart) begin
      n.pre = 11'h000; // R12
      n.cnt = 16'h0000; // R12
    end else if (run) begin
      n.pre = tick ? 11'h000 : s.pre + 11'h001;
      if (tick) begin
        if (pwm_en) begin
          if (s.cnt == period) begin
            n.cnt = 16'h0000;
            n.evt = 1'b1;
          end else begin
            n.cnt = s.cnt + 16'h0001;
          end
        end else if (cap_mode) begin
          n.cnt = s.cnt + 16'h0001; // R11
        end else if (s.cnt == compare) begin
          n.cnt = 16'h0000; // R11
          n.evt = 1'b1;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
    end
    if (cap_mode && cap_edge) begin
      n.cap = s.cnt; // R2
      n.evt = 1'b1;
    end
    n.pwm = pwm_en && run && (s.cnt[15:8] < duty_high);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign count    = s.cnt;
  assign captured = s.cap;
  assign event_p  = s.evt;
  assign pwm      = s.pwm;

  restart_clear_a: assert property ( // R12
    @(posedge ref_clk) disable iff (!rst_n)
    restart |=> (s.cnt == 16'h0000))
    else $error("counter not cleared by restart");

  stop_hold_a: assert property ( // R12
    @(posedge ref_clk) disable iff (!rst_n)
    (!run && !restart) |=> $stable(s.cnt))
    else $error("stopped counter moved");

  div_one_a: assert property ( // R13
    @(posedge ref_clk) disable iff (!rst_n)
    (run && !restart && clk_sel == 3'h0 && !pwm_en && !cap_mode &&
     s.pre == 11'h000 && s.cnt != compare)
    |=> (s.cnt == $past(s.cnt) + 16'h0001))
    else $error("undivided clock did not count every cycle");

  capture_take_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!rst_n)
    (cap_mode && cap_edge) |=> (s.cap == $past(s.cnt)))
    else $error("capture did not take the counter value");
endmodule // tmr_chan

//--- verilog/tmr_regs.sv
// register file, bus slave and irq status for timer channels 2 to 5
// assumes avalon-mm master on ref_clk; capture pins are asynchronous
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
// Notes on behaviour
// R1: read high address gives counter upper byte
// R2: capture high byte shares that address, read-only
// R3: high address write loads duty, pwm only
// R4: compare low byte write-only, resets ff
// R5: compare high byte write-only, resets ff
// R6: pwm mode routes low write to period
// R7: pwm mode routes high write to period
// R8: status holds six flags, top bits zero
// R9: flag sets on event, write one clears
// R10: flags set regardless of interrupt enable
// R11: capture bit picks capture or timer mode
// R12: start one clears and runs, zero stops
// R13: clock select divides by 1 to 2048
// R14: capture mode reads capture, else counter
module tmr_regs (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // timer 0 and 1 events, one-cycle pulses from ref_clk logic
  input  wire logic [1:0]  ext_tmr_evt,
  // capture pins of channels 2 to 5
  input  wire logic [3:0]  cap_pin,
  // channel outputs
  output logic      [3:0]  pwm_out,
  output logic             irq
);
  typedef struct packed {
    logic [3:0][7:0] ctrl;
    logic [3:0][7:0] cmp_lo;
    logic [3:0][7:0] cmp_hi;
    logic [3:0][7:0] per_lo;
    logic [3:0][7:0] per_hi;
    logic [3:0][7:0] duty_hi;
    logic [5:0]      status;
    logic [5:0]      irq_en;
    logic [3:0]      sync1;
    logic [3:0]      sync2;
    logic [3:0]      cap_prev;
    logic [3:0]      restart;
    logic            wait_r;
    logic [31:0]     rdata;
    logic            irq;
  } tmr_top_st_t;

  tmr_top_st_t s;
  tmr_top_st_t n;
  logic        req;
  logic        wr_go;
  logic [3:0]  cap_edge;
  logic [3:0]  chan_evt;
  logic [3:0]  chan_pwm;
  logic [5:0]  set_flags;
  logic [5:0]  clr_flags;
  logic [15:0] chan_cnt [tmr_pkg::NCH];
  logic [15:0] chan_cap [tmr_pkg::NCH];

  // word decode of the bus address against a register index
  function automatic logic hit(input logic [13:0] idx);
    hit = (avs_address[15:2] == idx) && (avs_address[1:0] == 2'h0);
  endfunction

  // read data for the current address
  function automatic logic [31:0] rd_mux(input tmr_top_st_t st);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < tmr_pkg::NCH; i++) begin
      if (hit(tmr_pkg::CNT_HI_IDX[i])) begin
        if (st.ctrl[i][tmr_pkg::CTL_CAP]) begin
          r = {24'h00_0000, chan_cap[i][15:8]}; // R14
        end else begin
          r = {24'h00_0000, chan_cnt[i][15:8]}; // R1
        end
      end else if (hit(tmr_pkg::CTRL_IDX[i])) begin
        r = {24'h00_0000, st.ctrl[i]};
      end
    end
    if (hit(tmr_pkg::STATUS_IDX)) begin
      r = {26'h000_0000, st.status}; // R8
    end else if (hit(tmr_pkg::IRQ_EN_IDX)) begin
      r = {26'h000_0000, st.irq_en};
    end
    rd_mux = r;
  endfunction

  // bus strobes and capture edges
  assign req       = avs_read | avs_write;
  assign wr_go     = avs_write & ~s.wait_r & avs_byteenable[0];
  assign cap_edge  = s.sync2 & ~s.cap_prev;
  assign set_flags = {chan_evt, ext_tmr_evt}; // R10

  // write-one clears from status register and clear register
  always_comb begin
    clr_flags = 6'h00;
    if (wr_go && hit(tmr_pkg::STATUS_IDX)) begin
      clr_flags = avs_writedata[5:0]; // R9
    end else if (wr_go && hit(tmr_pkg::IRQ_CLR_IDX)) begin
      clr_flags = avs_writedata[5:0];
    end
  end

  // next state of registers, bus handshake and irq
  always_comb begin
    n         = s;
    n.restart = 4'h0;
    n.sync1   = cap_pin;
    n.sync2   = s.sync1;
    n.cap_prev = s.sync2;
    if (req && s.wait_r) begin
      n.wait_r = 1'b0;
      n.rdata  = rd_mux(s);
    end else begin
      n.wait_r = 1'b1;
    end
    for (int i = 0; i < tmr_pkg::NCH; i++) begin
      if (wr_go && hit(tmr_pkg::CTRL_IDX[i])) begin
        n.ctrl[i]    = avs_writedata[7:0]; // R11
        n.restart[i] = avs_writedata[tmr_pkg::CTL_START]; // R12
      end else if (wr_go && hit(tmr_pkg::CNT_HI_IDX[i])) begin
        if (s.ctrl[i][tmr_pkg::CTL_PWM]) begin
          n.duty_hi[i] = avs_writedata[7:0]; // R3
        end
      end else if (wr_go && hit(tmr_pkg::CMP_LO_IDX[i])) begin
        if (s.ctrl[i][tmr_pkg::CTL_PWM]) begin
          n.per_lo[i] = avs_writedata[7:0]; // R6
        end else begin
          n.cmp_lo[i] = avs_writedata[7:0]; // R4
        end
      end else if (wr_go && hit(tmr_pkg::CMP_HI_IDX[i])) begin
        if (s.ctrl[i][tmr_pkg::CTL_PWM]) begin
          n.per_hi[i] = avs_writedata[7:0]; // R7
        end else begin
          n.cmp_hi[i] = avs_writedata[7:0]; // R5
        end
      end
    end
    if (wr_go && hit(tmr_pkg::IRQ_EN_IDX)) begin
      n.irq_en = avs_writedata[5:0];
    end
    // set wins over a clear in the same cycle
    n.status = (s.status & ~clr_flags) | set_flags; // R9
    n.irq    = |(n.status & n.irq_en);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s         <= '0;
      s.ctrl    <= {4{tmr_pkg::RST_CTRL}};
      s.cmp_lo  <= {4{tmr_pkg::RST_CMP}}; // R4
      s.cmp_hi  <= {4{tmr_pkg::RST_CMP}}; // R5
      s.per_lo  <= {4{tmr_pkg::RST_PER}}; // R6
      s.per_hi  <= {4{tmr_pkg::RST_PER}}; // R7
      s.duty_hi <= {4{tmr_pkg::RST_DUTY}}; // R3
      s.status  <= tmr_pkg::RST_STATUS; // R8
      s.irq_en  <= tmr_pkg::RST_IRQ_EN;
      s.wait_r  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // the four channels, timers 2 to 5
  for (genvar g = 0; g < tmr_pkg::NCH; g++) begin : g_chan
    tmr_chan u_chan (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .restart   (s.restart[g]),
      .run       (s.ctrl[g][tmr_pkg::CTL_START]),
      .cap_mode  (s.ctrl[g][tmr_pkg::CTL_CAP]),
      .pwm_en    (s.ctrl[g][tmr_pkg::CTL_PWM]),
      .clk_sel   (s.ctrl[g][tmr_pkg::CTL_CLK_LO +: 3]),
      .compare   ({s.cmp_hi[g], s.cmp_lo[g]}),
      .period    ({s.per_hi[g], s.per_lo[g]}),
      .duty_high (s.duty_hi[g]),
      .cap_edge  (cap_edge[g]),
      .count     (chan_cnt[g]),
      .captured  (chan_cap[g]),
      .event_p   (chan_evt[g]),
      .pwm       (chan_pwm[g])
    );
  end

  // outputs, all from flip-flops
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wait_r;
  assign pwm_out         = chan_pwm;
  assign irq             = s.irq;

  flag_set_a: assert property ( // R10
    @(posedge ref_clk) disable iff (!rst_n)
    ext_tmr_evt[0] |=> s.status[0])
    else $error("timer 0 event did not set its flag");

  flag_clear_a: assert property ( // R9
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::STATUS_IDX) && avs_writedata[1] &&
     !ext_tmr_evt[1]) |=> !s.status[1])
    else $error("write one did not clear flag");

  count_read_a: assert property ( // R1
    @(posedge ref_clk) disable iff (!rst_n)
    (req && s.wait_r && hit(tmr_pkg::CNT_HI_IDX[0]) &&
     !s.ctrl[0][tmr_pkg::CTL_CAP])
    |=> (s.rdata == {24'h00_0000, $past(chan_cnt[0][15:8])}))
    else $error("counter high byte read wrong");

  capture_read_a: assert property ( // R14
    @(posedge ref_clk) disable iff (!rst_n)
    (req && s.wait_r && hit(tmr_pkg::CNT_HI_IDX[1]) &&
     s.ctrl[1][tmr_pkg::CTL_CAP])
    |=> (s.rdata == {24'h00_0000, $past(chan_cap[1][15:8])}))
    else $error("capture high byte read wrong");

  status_read_a: assert property ( // R8
    @(posedge ref_clk) disable iff (!rst_n)
    (req && s.wait_r && hit(tmr_pkg::STATUS_IDX))
    |=> (s.rdata[31:6] == 26'h000_0000) && !s.wait_r)
    else $error("status read shows high bits");

  duty_gate_a: assert property ( // R3
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CNT_HI_IDX[2]) &&
     !s.ctrl[2][tmr_pkg::CTL_PWM]) |=> $stable(s.duty_hi[2]))
    else $error("duty changed outside pwm");

  period_route_a: assert property ( // R6
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CMP_LO_IDX[2]) &&
     s.ctrl[2][tmr_pkg::CTL_PWM])
    |=> (s.per_lo[2] == $past(avs_writedata[7:0])) &&
        $stable(s.cmp_lo[2]))
    else $error("pwm low write not routed to period");

  compare_route_a: assert property ( // R5
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CMP_HI_IDX[0]) &&
     !s.ctrl[0][tmr_pkg::CTL_PWM])
    |=> (s.cmp_hi[0] == $past(avs_writedata[7:0])) &&
        $stable(s.per_hi[0]))
    else $error("compare high write lost");

  period_high_a: assert property ( // R7
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CMP_HI_IDX[2]) &&
     s.ctrl[2][tmr_pkg::CTL_PWM])
    |=> (s.per_hi[2] == $past(avs_writedata[7:0])))
    else $error("pwm high write not routed to period");

  // further register, flag and read-back checks
  compare_low_a: assert property ( // R4
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CMP_LO_IDX[0]) &&
     !s.ctrl[0][tmr_pkg::CTL_PWM])
    |=> (s.cmp_lo[0] == $past(avs_writedata[7:0])) &&
        $stable(s.per_lo[0]))
    else $error("compare low write lost");

  duty_load_a: assert property ( // R3
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CNT_HI_IDX[2]) &&
     s.ctrl[2][tmr_pkg::CTL_PWM])
    |=> (s.duty_hi[2] == $past(avs_writedata[7:0])))
    else $error("duty high write lost in pwm");

  compare_keep_a: assert property ( // R7
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CMP_HI_IDX[2]) &&
     s.ctrl[2][tmr_pkg::CTL_PWM])
    |=> $stable(s.cmp_hi[2]))
    else $error("pwm high write reached compare");

  clear_reg_a: assert property ( // R9
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::IRQ_CLR_IDX) && avs_writedata[0] &&
     !ext_tmr_evt[0]) |=> !s.status[0])
    else $error("clear register did not clear flag");

  flag_sticky_a: assert property ( // R9
    @(posedge ref_clk) disable iff (!rst_n)
    (clr_flags == 6'h00)
    |=> ((s.status & $past(s.status)) == $past(s.status)))
    else $error("flag dropped without a clear");

  chan_flag_a: assert property ( // R10
    @(posedge ref_clk) disable iff (!rst_n)
    (|chan_evt)
    |=> ((s.status[5:2] & $past(chan_evt)) == $past(chan_evt)))
    else $error("channel event did not set its flag");

  irq_level_a: assert property ( // R10
    @(posedge ref_clk) disable iff (!rst_n)
    s.irq == |(s.status & s.irq_en))
    else $error("irq level disagrees with flags");

  ctrl_load_a: assert property ( // R11
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CTRL_IDX[1]))
    |=> (s.ctrl[1] == $past(avs_writedata[7:0])))
    else $error("control write lost");

  restart_pulse_a: assert property ( // R12
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && hit(tmr_pkg::CTRL_IDX[0]) &&
     avs_writedata[tmr_pkg::CTL_START]) |=> s.restart[0])
    else $error("start write gave no restart");

  restart_once_a: assert property ( // R12
    @(posedge ref_clk) disable iff (!rst_n)
    s.restart[0] |=> !s.restart[0])
    else $error("restart longer than one cycle");

  capture_flag_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!rst_n)
    (cap_edge[1] && s.ctrl[1][tmr_pkg::CTL_CAP])
    |=> ##1 s.status[3])
    else $error("capture edge did not set its flag");

  status_value_a: assert property ( // R8
    @(posedge ref_clk) disable iff (!rst_n)
    (req && s.wait_r && hit(tmr_pkg::STATUS_IDX))
    |=> (s.rdata[5:0] == $past(s.status)))
    else $error("status read shows wrong flags");

  timer5_read_a: assert property ( // R1
    @(posedge ref_clk) disable iff (!rst_n)
    (req && s.wait_r && hit(tmr_pkg::CNT_HI_IDX[3]) &&
     !s.ctrl[3][tmr_pkg::CTL_CAP])
    |=> (s.rdata == {24'h00_0000, $past(chan_cnt[3][15:8])}))
    else $error("timer 5 high byte read wrong");

  mode_read_a: assert property ( // R14
    @(posedge ref_clk) disable iff (!rst_n)
    (req && s.wait_r && hit(tmr_pkg::CNT_HI_IDX[1]) &&
     !s.ctrl[1][tmr_pkg::CTL_CAP])
    |=> (s.rdata[7:0] == $past(chan_cnt[1][15:8])))
    else $error("timer mode read did not show counter");
endmodule // tmr_regs

//--- dv/tb_top.sv
// self-checking bench for the timer upper-byte registers and irq status
// assumes tmr_regs alone, driven over avalon-mm on a 200 MHz ref_clk
`timescale 1ns/10ps
module tb_top;
  // clock and reset
  logic        ref_clk;
  logic        rst_n;
  // avalon-mm master side
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  // events, pins and outputs
  logic [1:0]  ext_tmr_evt;
  logic [3:0]  cap_pin;
  logic [3:0]  pwm_out;
  logic        irq;
  int          fail_count;
  int          total_checks;
  int          n;

  tmr_regs uut (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .ext_tmr_evt     (ext_tmr_evt),
    .cap_pin         (cap_pin),
    .pwm_out         (pwm_out),
    .irq             (irq)
  );

  // free-running 5 ns clock
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // value compare, counts every call
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [13:0] idx,
                     input logic [7:0] wd, output logic [31:0] rdata);
    int i;
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 20) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, idx, 8'h00, got);
    chk(got, exp);
  endtask

  task automatic tick(input int cycles);
    repeat (cycles) @(posedge ref_clk);
  endtask

  // count high cycles of channel 4 pwm over 1024 cycles
  task automatic cnt_pwm(output int c);
    c = 0;
    @(posedge ref_clk); // first sample still predates a change
    repeat (1024) begin
      @(posedge ref_clk);
      if (pwm_out[2] === 1'b1) c++;
    end
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq(input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(posedge ref_clk);
      if (irq === 1'b1) break;
    end
    if (i == bound) begin
      fail_count++;
      finish_test();
    end
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h00000000;
    ext_tmr_evt = 2'b00;
    cap_pin = 4'h0;
    fail_count = 0;
    total_checks = 0;
    tick(5);
    rst_n <= 1'b1;
    tick(1);
    chk({31'h0, avs_waitrequest}, 32'h1);
    // reset values and an unmapped place
    rd(tmr_pkg::STATUS_IDX, 32'h0);
    rd(tmr_pkg::IRQ_EN_IDX, 32'h0);
    rd(tmr_pkg::CTRL_IDX[1], 32'h0);
    rd(tmr_pkg::CNT_HI_IDX[1], 32'h0);
    rd(14'h0001, 32'h0);
    // a write with byte lane 0 off is ignored
    avs_byteenable <= 4'hE;
    wr(tmr_pkg::IRQ_EN_IDX, 8'h3F);
    avs_byteenable <= 4'hF;
    rd(tmr_pkg::IRQ_EN_IDX, 32'h0);
    // timers 0 and 1 raise flags while masked
    tick(1);
    ext_tmr_evt <= 2'b11;
    tick(1);
    ext_tmr_evt <= 2'b00;
    rd(tmr_pkg::STATUS_IDX, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(tmr_pkg::IRQ_EN_IDX, 8'h01);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(tmr_pkg::STATUS_IDX, 8'h02);
    rd(tmr_pkg::STATUS_IDX, 32'h1);
    wr(tmr_pkg::IRQ_CLR_IDX, 8'h01);
    rd(tmr_pkg::STATUS_IDX, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // timer 2 compare match at 0x0300
    wr(tmr_pkg::CMP_LO_IDX[0], 8'h00);
    wr(tmr_pkg::CMP_HI_IDX[0], 8'h03);
    wr(tmr_pkg::IRQ_EN_IDX, 8'h04);
    wr(tmr_pkg::CTRL_IDX[0], 8'h01);
    tick(300);
    rd(tmr_pkg::CNT_HI_IDX[0], 32'h1);
    chk({31'h0, irq}, 32'h0);
    wait_irq(500);
    rd(tmr_pkg::STATUS_IDX, 32'h4);
    wr(tmr_pkg::STATUS_IDX, 8'h04);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    wr(tmr_pkg::CTRL_IDX[0], 8'h00);
    // timer 3 capture holds its high byte
    wr(tmr_pkg::CTRL_IDX[1], 8'h21);
    tick(300);
    cap_pin[1] <= 1'b1;
    tick(4);
    cap_pin[1] <= 1'b0;
    tick(300);
    rd(tmr_pkg::CNT_HI_IDX[1], 32'h1);
    rd(tmr_pkg::STATUS_IDX, 32'h8);
    wr(tmr_pkg::STATUS_IDX, 8'h08);
    wr(tmr_pkg::CTRL_IDX[1], 8'h00);
    // timer 4 pwm: duty refused while off, period 0x03FF
    wr(tmr_pkg::CNT_HI_IDX[2], 8'h02);
    wr(tmr_pkg::CTRL_IDX[2], 8'h41);
    wr(tmr_pkg::CMP_LO_IDX[2], 8'hFF);
    wr(tmr_pkg::CMP_HI_IDX[2], 8'h03);
    cnt_pwm(n);
    chk(32'(n), 32'h0);
    wr(tmr_pkg::CNT_HI_IDX[2], 8'h02);
    cnt_pwm(n);
    chk(32'(n), 32'h200);
    rd(tmr_pkg::STATUS_IDX, 32'h10);
    wr(tmr_pkg::CTRL_IDX[2], 8'h00);
    wr(tmr_pkg::STATUS_IDX, 8'h10);
    // timer 5 counts at a quarter of ref_clk
    wr(tmr_pkg::CTRL_IDX[3], 8'h05);
    tick(1100);
    rd(tmr_pkg::CNT_HI_IDX[3], 32'h1);
    wr(tmr_pkg::CTRL_IDX[3], 8'h00);
    // unused top bits stay zero
    wr(tmr_pkg::IRQ_EN_IDX, 8'hFF);
    rd(tmr_pkg::IRQ_EN_IDX, 32'h3F);
    tick(1);
    ext_tmr_evt <= 2'b11;
    tick(1);
    ext_tmr_evt <= 2'b00;
    rd(tmr_pkg::STATUS_IDX, 32'h3);
    wr(tmr_pkg::STATUS_IDX, 8'hFF);
    rd(tmr_pkg::STATUS_IDX, 32'h0);
    chk({31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule // tb_top
